// file: design/cfsc_defs.svh
// Purpose: constants of the clock fan-out buffer and its serial configuration port
// Assumes: included by the package file, the checker and the testbench
// Notes: definitions only
`ifndef CFSC_DEFS_SVH
`define CFSC_DEFS_SVH

// ================================================================
// serial slave address and frame positions
`define CFSC_SLAVE_ADDR 8'hd2
`define CFSC_POS_ADDR 4'h0
`define CFSC_POS_CMD 4'h1
`define CFSC_POS_COUNT 4'h2
`define CFSC_POS_DATA0 4'h3
`define CFSC_POS_DATA1 4'h4
`define CFSC_POS_DATA2 4'h5
`define CFSC_POS_LAST 4'hf
`define CFSC_LAST_BIT 3'h7

// ================================================================
// enable field lanes inside data bytes 0..2
`define CFSC_D0_TOP_BIT 3'h3
`define CFSC_D1_LOW_BIT 3'h4
`define CFSC_D2_LOW_BIT 3'h6
`define CFSC_D2_OUT_OFS 4'h2

// ================================================================
// reset value and output count
`define CFSC_EN_RESET 10'h3ff
`define CFSC_NUM_OUT 10

`endif

// file: design/cfsc_pkg.sv
// Purpose: types of the clock fan-out buffer
// Assumes: cfsc_defs.svh for widths and values
// Notes: one packed struct holds all state of the top module apart from the pin synchronisers
`include "cfsc_defs.svh"

package cfsc_pkg;

    // ================================================================
    // serial receiver states
    typedef enum logic [4:0] {
        CFSC_ST_IDLE = 5'h01,
        CFSC_ST_ADDR = 5'h02,
        CFSC_ST_ACK  = 5'h04,
        CFSC_ST_DATA = 5'h08,
        CFSC_ST_SKIP = 5'h10
    } cfsc_state_t;

    // ================================================================
    // whole state of the top module apart from the pin synchronisers
    typedef struct packed {
        cfsc_state_t st;
        logic [2:0] bit_cnt;
        logic got8;
        logic [3:0] byte_idx;
        logic [7:0] shift;
        logic [`CFSC_NUM_OUT-1:0] en;
        logic sda_oe;
        logic scl_q;
        logic sda_q;
    } cfsc_regs_t;

endpackage

// file: design/cfsc_sync.sv
// Purpose: two flip-flop synchroniser for one pin
// Assumes: input is asynchronous to CLK
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps

module cfsc_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic d,
    output logic q
);

    logic meta_ff;
    logic sync_ff;

    // ================================================================
    // two stages
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_ff <= 1'h1;
            sync_ff <= 1'h1;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule

// file: design/cfsc_top.sv
// Purpose: ten-output clock fan-out buffer with a write-only serial configuration slave
// Assumes: CLK at 10 MHz, serial clock far slower; reference clock passes ungated by CLK
// Notes: each enable bit takes effect on the serial clock fall that closes its bit
`timescale 1ns/10ps

module cfsc_top
    import cfsc_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic REF_CLOCK_IN,
    input wire logic OUTPUT_ENABLE_PIN,
    input wire logic SERIAL_CLOCK_PIN,
    input wire logic SERIAL_DATA_PIN_I,
    output logic SERIAL_DATA_PIN_O,
    output logic SERIAL_DATA_PIN_OE,
    output logic [`CFSC_NUM_OUT-1:0] FANOUT_CLOCK_OUTPUTS,
    output logic [`CFSC_NUM_OUT-1:0] FANOUT_CLOCK_OUTPUTS_OE,
    output logic [`CFSC_NUM_OUT-1:0] CLOCK_ENABLES
);

    // ================================================================
    // lane decode: which output an incoming data bit steers
    // returns {hit, output index}
    function automatic logic [4:0] cfsc_lane(
        input logic [3:0] byte_idx,
        input logic [2:0] bit_pos
    );
        logic [4:0] res;
        res = 5'h00;
        unique case (byte_idx)
            `CFSC_POS_DATA0: begin
                if (bit_pos <= `CFSC_D0_TOP_BIT) begin
                    res = {1'h1, 1'h0, bit_pos};
                end
            end
            `CFSC_POS_DATA1: begin
                if (bit_pos >= `CFSC_D1_LOW_BIT) begin
                    res = {1'h1, 1'h0, bit_pos};
                end
            end
            `CFSC_POS_DATA2: begin
                if (bit_pos >= `CFSC_D2_LOW_BIT) begin
                    res = {1'h1, 4'({1'h0, bit_pos} + `CFSC_D2_OUT_OFS)};
                end
            end
            default: begin
                res = 5'h00;
            end
        endcase
        return res;
    endfunction

    // ================================================================
    // pin synchronisers
    logic scl_s;
    logic sda_s;
    logic oe_s;

    cfsc_sync u_sync_scl (
        .clk(CLK),
        .reset(RESET),
        .d(SERIAL_CLOCK_PIN),
        .q(scl_s)
    );

    cfsc_sync u_sync_sda (
        .clk(CLK),
        .reset(RESET),
        .d(SERIAL_DATA_PIN_I),
        .q(sda_s)
    );

    cfsc_sync u_sync_oe (
        .clk(CLK),
        .reset(RESET),
        .d(OUTPUT_ENABLE_PIN),
        .q(oe_s)
    );

    // ================================================================
    // state
    cfsc_regs_t r_ff;
    cfsc_regs_t nxt_r;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [4:0] lane;
    logic [2:0] bit_pos;
    logic bit_held;
    logic [2:0] rx_cnt;

    always_comb begin
        scl_rise = scl_s & ~r_ff.scl_q;
        scl_fall = ~scl_s & r_ff.scl_q;
        // data moving while clock stays high frames the transfer
        start_cond = scl_s & r_ff.scl_q & r_ff.sda_q & ~sda_s;
        stop_cond = scl_s & r_ff.scl_q & ~r_ff.sda_q & sda_s;
        // the bit most recently taken: bit_cnt has already moved past it unless got8
        bit_held = r_ff.got8 | (r_ff.bit_cnt != 3'h0);
        rx_cnt = r_ff.got8 ? `CFSC_LAST_BIT : 3'(r_ff.bit_cnt - 3'h1);
        bit_pos = 3'(`CFSC_LAST_BIT - rx_cnt);
        lane = cfsc_lane(r_ff.byte_idx, bit_pos);

        nxt_r = r_ff;
        nxt_r.scl_q = scl_s;
        nxt_r.sda_q = sda_s;

        if (start_cond) begin
            // restart truncates any transfer in flight
            nxt_r.st = CFSC_ST_ADDR;
            nxt_r.bit_cnt = 3'h0;
            nxt_r.got8 = 1'h0;
            nxt_r.byte_idx = `CFSC_POS_ADDR;
            nxt_r.sda_oe = 1'h0;
        end else if (stop_cond) begin
            nxt_r.st = CFSC_ST_IDLE;
            nxt_r.sda_oe = 1'h0;
        end else begin
            unique case (r_ff.st)
                CFSC_ST_IDLE: begin
                    nxt_r.sda_oe = 1'h0;
                end
                CFSC_ST_ADDR: begin
                    if (scl_rise) begin
                        nxt_r.shift = {r_ff.shift[6:0], sda_s};
                        if (r_ff.bit_cnt == `CFSC_LAST_BIT) begin
                            nxt_r.got8 = 1'h1;
                        end else begin
                            nxt_r.bit_cnt = 3'(r_ff.bit_cnt + 3'h1);
                        end
                    end
                    if (scl_fall && r_ff.got8) begin
                        nxt_r.got8 = 1'h0;
                        nxt_r.bit_cnt = 3'h0;
                        if (r_ff.shift == `CFSC_SLAVE_ADDR) begin
                            nxt_r.st = CFSC_ST_ACK;
                            nxt_r.sda_oe = 1'h1;
                        end else begin
                            // foreign address: no ack, no register touched
                            nxt_r.st = CFSC_ST_SKIP;
                        end
                    end
                end
                CFSC_ST_ACK: begin
                    // hold data low through the ninth clock, release on its fall
                    if (scl_fall) begin
                        nxt_r.sda_oe = 1'h0;
                        nxt_r.st = CFSC_ST_DATA;
                        // command and count only advance the position
                        if (r_ff.byte_idx != `CFSC_POS_LAST) begin
                            nxt_r.byte_idx = 4'(r_ff.byte_idx + 4'h1);
                        end
                    end
                end
                CFSC_ST_DATA: begin
                    if (scl_rise) begin
                        nxt_r.shift = {r_ff.shift[6:0], sda_s};
                        if (r_ff.bit_cnt == `CFSC_LAST_BIT) begin
                            nxt_r.got8 = 1'h1;
                        end else begin
                            nxt_r.bit_cnt = 3'(r_ff.bit_cnt + 3'h1);
                        end
                    end
                    // no double buffering: a bit lands on the fall that ends its high phase,
                    // so the clock pulse of a stop or restart never writes a register
                    if (scl_fall && bit_held && lane[4]) begin
                        nxt_r.en[lane[3:0]] = r_ff.shift[0];
                    end
                    if (scl_fall && r_ff.got8) begin
                        // every byte is acked, count byte never limits it
                        nxt_r.got8 = 1'h0;
                        nxt_r.bit_cnt = 3'h0;
                        nxt_r.st = CFSC_ST_ACK;
                        nxt_r.sda_oe = 1'h1;
                    end
                end
                CFSC_ST_SKIP: begin
                    nxt_r.sda_oe = 1'h0;
                end
                default: begin
                    nxt_r.st = CFSC_ST_IDLE;
                    nxt_r.sda_oe = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            r_ff.st <= CFSC_ST_IDLE;
            r_ff.bit_cnt <= 3'h0;
            r_ff.got8 <= 1'h0;
            r_ff.byte_idx <= `CFSC_POS_ADDR;
            r_ff.shift <= 8'h00;
            r_ff.en <= `CFSC_EN_RESET;
            r_ff.sda_oe <= 1'h0;
            r_ff.scl_q <= 1'h1;
            r_ff.sda_q <= 1'h1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ================================================================
    // fan-out path
    // the reference clock is gated, never resampled: sampling at 10 MHz
    // could not follow it. an enable change while it is high may clip a pulse.
    always_comb begin
        for (int i = 0; i < `CFSC_NUM_OUT; i++) begin
            FANOUT_CLOCK_OUTPUTS[i] = REF_CLOCK_IN & r_ff.en[i];
            FANOUT_CLOCK_OUTPUTS_OE[i] = oe_s;
        end
    end

    assign SERIAL_DATA_PIN_O = 1'h0;
    assign SERIAL_DATA_PIN_OE = r_ff.sda_oe;
    assign CLOCK_ENABLES = r_ff.en;

endmodule

// file: bench/cfsc_host.sv
// Purpose: serial host model that writes frames to the fan-out buffer
// Assumes: clock phases of 4 CLK periods, 800 ns per serial bit
// Notes: clock idles high between frames; a released data line reads as the pull-up
`timescale 1ns/10ps

module cfsc_host (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    // ================================================================
    // bus phases
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // data moves one CLK after the clock falls, so it never looks like a start or stop
    task automatic pulse(input logic v, output logic seen);
        @(negedge clk);
        sda = v;
        repeat (3) @(negedge clk);
        scl = 1'b1;
        half();
        seen = sda_line;
        scl = 1'b0;
    endtask

    task automatic start();
        @(negedge clk);
        sda = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda = 1'b0;
        half();
        scl = 1'b0;
    endtask

    task automatic send(input logic [7:0] b, output logic seen);
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i], seen);
        end
        pulse(1'b1, seen);
    endtask

    task automatic stop();
        @(negedge clk);
        sda = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda = 1'b1;
        half();
    endtask
endmodule

// file: bench/cfsc_top_assertions.sv
// Purpose: port checker for cfsc_top
// Assumes: host clock phases of at least 4 CLK
// Notes: bound to every cfsc_top instance
`timescale 1ns/10ps
`include "cfsc_defs.svh"

module cfsc_chk (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic REF_CLOCK_IN,
    input wire logic OUTPUT_ENABLE_PIN,
    input wire logic SERIAL_CLOCK_PIN,
    input wire logic SERIAL_DATA_PIN_I,
    input wire logic SERIAL_DATA_PIN_O,
    input wire logic SERIAL_DATA_PIN_OE,
    input wire logic [`CFSC_NUM_OUT-1:0] FANOUT_CLOCK_OUTPUTS,
    input wire logic [`CFSC_NUM_OUT-1:0] FANOUT_CLOCK_OUTPUTS_OE,
    input wire logic [`CFSC_NUM_OUT-1:0] CLOCK_ENABLES
);
    // ================================================================
    // properties
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    // four samples cover the two synchroniser stages, which drive the output enables directly
    oe_on_a: assert property (OUTPUT_ENABLE_PIN [*4] |-> &FANOUT_CLOCK_OUTPUTS_OE)
        else $error("outputs not driven");
    oe_off_a: assert property (!OUTPUT_ENABLE_PIN [*4] |-> !(|FANOUT_CLOCK_OUTPUTS_OE))
        else $error("outputs not released");
    out_gate_a: assert property (FANOUT_CLOCK_OUTPUTS ==
        ({`CFSC_NUM_OUT{REF_CLOCK_IN}} & CLOCK_ENABLES)) else $error("output gating wrong");
    ack_low_clk_a: assert property ($rose(SERIAL_DATA_PIN_OE) |-> !SERIAL_CLOCK_PIN)
        else $error("ack raised while clock high");
    ack_hold_a: assert property ($rose(SERIAL_CLOCK_PIN) && SERIAL_DATA_PIN_OE |=>
        SERIAL_DATA_PIN_OE [*3]) else $error("ack dropped early");
    ack_end_a: assert property ($fell(SERIAL_CLOCK_PIN) && SERIAL_DATA_PIN_OE |->
        ##[1:4] !SERIAL_DATA_PIN_OE) else $error("ack held too long");
    drive_low_a: assert property (SERIAL_DATA_PIN_O == 1'b0)
        else $error("data pin driven high");
    // a bit is applied only after its high phase closed without a stop or restart
    en_edge_a: assert property (!$stable(CLOCK_ENABLES) |-> !SERIAL_CLOCK_PIN)
        else $error("enable change while clock high");
    en_bit_a: assert property (!$stable(CLOCK_ENABLES) |->
        $onehot(CLOCK_ENABLES ^ $past(CLOCK_ENABLES))) else $error("several enables at once");

    cover property ($rose(SERIAL_DATA_PIN_OE));
    cover property ($fell(FANOUT_CLOCK_OUTPUTS_OE[0]));
    cover property (!$stable(CLOCK_ENABLES));
endmodule

bind cfsc_top cfsc_chk cfsc_chk_i (.CLK(CLK), .RESET(RESET), .REF_CLOCK_IN(REF_CLOCK_IN),
    .OUTPUT_ENABLE_PIN(OUTPUT_ENABLE_PIN), .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN),
    .SERIAL_DATA_PIN_I(SERIAL_DATA_PIN_I), .SERIAL_DATA_PIN_O(SERIAL_DATA_PIN_O),
    .SERIAL_DATA_PIN_OE(SERIAL_DATA_PIN_OE), .FANOUT_CLOCK_OUTPUTS(FANOUT_CLOCK_OUTPUTS),
    .FANOUT_CLOCK_OUTPUTS_OE(FANOUT_CLOCK_OUTPUTS_OE), .CLOCK_ENABLES(CLOCK_ENABLES));

// file: bench/testbench.sv
// Purpose: self-checking bench for cfsc_top
// Assumes: cfsc_host drives the serial pins
// Notes: frames are fixed tables; no random stimulus
`timescale 1ns/10ps
`include "cfsc_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

module testbench;
    // ================================================================
    // wiring
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic ref_clk = 1'b0;
    logic oe_pin = 1'b1;
    logic sda_o, sda_oe;
    logic [9:0] outs, outs_oe, ens;
    logic [7:0] f [10];
    wire scl, host_sda;
    wire sda_wire = host_sda & (~sda_oe | sda_o);
    int n_fail = 0;
    int total_checks = 0;

    always #50 CLK = ~CLK;

    cfsc_top cfsc_top_i (.CLK(CLK), .RESET(RESET), .REF_CLOCK_IN(ref_clk),
        .OUTPUT_ENABLE_PIN(oe_pin), .SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_PIN_I(sda_wire),
        .SERIAL_DATA_PIN_O(sda_o), .SERIAL_DATA_PIN_OE(sda_oe), .FANOUT_CLOCK_OUTPUTS(outs),
        .FANOUT_CLOCK_OUTPUTS_OE(outs_oe), .CLOCK_ENABLES(ens));
    cfsc_host cfsc_host_i (.clk(CLK), .sda_line(sda_wire), .scl(scl), .sda(host_sda));

    // ================================================================
    // tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic frame(input int n, input logic acked);
        logic seen;
        cfsc_host_i.start();
        for (int k = 0; k < n; k++) begin
            cfsc_host_i.send(f[k], seen);
            `CHK("ack", !acked, seen)
        end
        cfsc_host_i.stop();
    endtask

    // ================================================================
    // tests
    initial begin
        repeat (2) @(posedge CLK);
        @(negedge CLK) RESET = 1'b0;
        repeat (3) @(negedge CLK);
        `CHK("en_reset", 10'h3ff, ens)
        `CHK("oe_reset", 10'h3ff, outs_oe)
        ref_clk = 1'b1;
        #1 `CHK("outs_hi", 10'h3ff, outs)
        $display("test reset done");
        // count byte of zero must not stop the data; trailing ff bytes must be ignored
        f = '{8'hd2, 8'ha5, 8'h00, 8'hf5, 8'h5a, 8'h80, 8'hff, 8'hff, 8'hff, 8'hff};
        frame(10, 1'b1);
        `CHK("en_full", 10'h255, ens)
        `CHK("outs_en", 10'h255, outs)
        @(negedge CLK) ref_clk = 1'b0;
        #1 `CHK("outs_lo", 10'h000, outs)
        $display("test full frame done");
        f = '{8'hd3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        frame(10, 1'b0);
        `CHK("en_wrong_addr", 10'h255, ens)
        $display("test wrong address done");
        f[0] = 8'hd2;
        f[3] = 8'h0f;
        frame(4, 1'b1);
        `CHK("en_truncated", 10'h25f, ens)
        $display("test truncation done");
        @(negedge CLK) oe_pin = 1'b0;
        repeat (4) @(negedge CLK);
        `CHK("oe_off", 10'h000, outs_oe)
        oe_pin = 1'b1;
        repeat (4) @(negedge CLK);
        `CHK("oe_on", 10'h3ff, outs_oe)
        $display("test output enable done");
        @(negedge CLK) RESET = 1'b1;
        repeat (2) @(negedge CLK);
        RESET = 1'b0;
        repeat (3) @(negedge CLK);
        `CHK("en_rereset", 10'h3ff, ens)
        // the stop's own clock pulse must not write bit 7 of data byte 1
        f[3] = 8'h00;
        frame(4, 1'b1);
        `CHK("en_stop_clk", 10'h3f0, ens)
        $display("test reset and stop done");
        summarize();
    end

    initial begin
        repeat (100000) @(posedge CLK);
        n_fail++;
        summarize();
    end
endmodule
